// ### hdl/dslc_regs.svh
// Purpose: Constants for the DAC serial load front end
// Assumes: Included by the package and by every design file
// Notes:   Sizes and the clock ceiling are plain integers, other values are sized literals
`ifndef DSLC_REGS_SVH
`define DSLC_REGS_SVH

// Structure sizes
`define DSLC_CHANNELS     4
`define DSLC_DATA_W       16
`define DSLC_RB_W         24
`define DSLC_SHIFT_W      32
`define DSLC_CNT_W        6
`define DSLC_PIN_W        5

// Frame lengths in serial clock falling edges
`define DSLC_LEN_SHORT    6'h18
`define DSLC_LEN_LONG     6'h20
`define DSLC_CNT_SAT      6'h21
`define DSLC_CNT_ZERO     6'h00
`define DSLC_CNT_ONE      6'h01

// Register select field codes
`define DSLC_SEL_DATA     3'h0
`define DSLC_SEL_OUTPUT   3'h1

// Reset values
`define DSLC_DAC_RST      16'h0000
`define DSLC_RB_RST       24'h00_0000
`define DSLC_PIN_RST      5'h18

// Host serial clock ceiling, in MHz; the host keeps to it
`define DSLC_SCLK_MAX_MHZ 30

`endif

// ### hdl/dslc_pkg.sv
// Purpose: Types and shared helpers for the DAC serial load front end
// Assumes: dslc_regs.svh on the include path
// Notes:   Nothing here holds state
`include "dslc_regs.svh"

package dslc_pkg;

  // One 24-bit frame, most significant bit first on the wire
  typedef struct packed {
    logic                    read_req;
    logic [1:0]              dev_addr;
    logic [1:0]              channel;
    logic [2:0]              reg_sel;
    logic [`DSLC_DATA_W-1:0] data;
  } dslc_frame_t;

  // Outcome of a finished frame
  typedef enum logic [1:0] {
    DSLC_KIND_NONE,
    DSLC_KIND_WRITE,
    DSLC_KIND_READ,
    DSLC_KIND_DROP
  } dslc_kind_t;

  // Saturating bit counter step, shared by both link counters
  function automatic logic [`DSLC_CNT_W-1:0] dslc_sat_inc(input logic [`DSLC_CNT_W-1:0] v);
    if (v >= `DSLC_CNT_SAT) begin
      return `DSLC_CNT_SAT;
    end
    return v + `DSLC_CNT_ONE;
  endfunction

endpackage

// ### hdl/dslc_link.sv
// Purpose: Serial clock side of the front end: shift in, shift out
// Assumes: Serial clock idles low and stops outside frames
// Notes:   Frame sync presets the per-frame state; no other reset here
`timescale 1ns/1ps
`include "dslc_regs.svh"

module dslc_link (
  input  wire logic                     serial_clk,      // Link clock from host
  input  wire logic                     frame_sync_n,    // Frame sync, active low
  input  wire logic                     serial_data_in,  // Write bits from host
  input  wire logic [`DSLC_RB_W-1:0]    rb_word,         // Readback word, static in frame
  output logic      [`DSLC_SHIFT_W-1:0] shift_q,         // Captured frame bits
  output logic      [`DSLC_CNT_W-1:0]   cnt_q,           // Falling edges in frame
  output logic                          in_arm_q,        // High until first falling edge
  output logic                          serial_data_out  // Readback bit
);

  logic                   out_arm_q;
  logic [`DSLC_CNT_W-1:0] out_idx_q;
  wire  logic [`DSLC_CNT_W-1:0] cnt_next;
  wire  logic [`DSLC_CNT_W-1:0] out_pos;
  wire  logic                   out_bit;

  // First edge of a frame restarts the count; counts saturate
  assign cnt_next = in_arm_q ? `DSLC_CNT_ONE : dslc_pkg::dslc_sat_inc(cnt_q);
  assign out_pos  = out_arm_q ? `DSLC_CNT_ZERO : out_idx_q;
  // Past the word the line rests low
  assign out_bit  = (out_pos < `DSLC_LEN_SHORT) ? rb_word[`DSLC_RB_W-1-out_pos] : 1'b0;

  // Arm flag set by the idle frame sync, cleared by first fall
  always_ff @(negedge serial_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      in_arm_q <= 1'b1;
    end else begin
      in_arm_q <= 1'b0;
    end
  end

  // Shift in on falling edges; contents stay for the clk side
  always_ff @(negedge serial_clk) begin
    if (!frame_sync_n) begin
      cnt_q   <= cnt_next;                                          // R01
      shift_q <= {shift_q[`DSLC_SHIFT_W-2:0], serial_data_in};      // R01
    end
  end

  // Output side arm flag, same scheme on rising edges
  always_ff @(posedge serial_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      out_arm_q <= 1'b1;
    end else begin
      out_arm_q <= 1'b0;
    end
  end

  // Drive on rising edges so the host samples on the next fall
  always_ff @(posedge serial_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= out_bit;                                   // R04
    end
  end

  // Readback position, counted on the host clock
  always_ff @(posedge serial_clk) begin
    if (!frame_sync_n) begin
      out_idx_q <= dslc_pkg::dslc_sat_inc(out_pos);                 // R04
    end
  end

  // The register has no reset, so only the freshly shifted bits are compared
  property p_shift_in;
    @(negedge serial_clk) disable iff (frame_sync_n)
      !in_arm_q |=> (shift_q[1:0] == {$past(shift_q[0]), $past(serial_data_in)}) &&
                    (cnt_q == dslc_pkg::dslc_sat_inc($past(cnt_q)));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("frame bit not shifted in"); // R01

  property p_first_bit;
    @(negedge serial_clk) disable iff (frame_sync_n)
      in_arm_q |=> (cnt_q == `DSLC_CNT_ONE) && (shift_q[0] == $past(serial_data_in));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first frame bit not counted"); // R01

  property p_msb_out;
    @(posedge serial_clk) disable iff (frame_sync_n)
      (out_arm_q && !frame_sync_n) |=> (serial_data_out == $past(rb_word[`DSLC_RB_W-1])) ##1
        (serial_data_out == $past(rb_word[`DSLC_RB_W-2], 2));
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("readback not msb first"); // R04

endmodule

// ### hdl/dslc_top.sv
// Purpose: Serial load control of a quad current output DAC
// Assumes: Host clock on serial_clk, system clock on clk at 40 MHz
// Notes:   Frame words cross under the frame sync qualifier
//
// Summary of operation
// R01: With frame sync low each serial clock fall shifts one data bit into the input register.
// R02: The host keeps the serial clock at or below 30 MHz.
// R03: The host holds data stable at every serial clock fall of a frame.
// R04: In readback the selected register leaves on serial data out, clocked by the host clock.
// R05: With the load input held low a write updates the addressed output register at frame end.
// R06: With the load input high a write updates only the input register of that channel.
// R07: A falling load input copies every input register to its output register together.
// R08: The two address select pins must match the frame's device address for it to act.
// R09: The board avoids tying both address select pins low when packet checking is used.
// R10: A frame ends after the 24th or the 32nd falling edge, the longer one carrying check bits.
// R11: While clear is active no write reaches an output register.
// R12: Bits go most significant first and a frame of any other length updates nothing.
`timescale 1ns/1ps
`include "dslc_regs.svh"

module dslc_top (
  input  wire logic                         clk,                // System clock, 40 MHz
  input  wire logic                         reset,              // Synchronous, active high
  input  wire logic                         serial_clk,         // Host serial clock
  input  wire logic                         frame_sync_n,       // Frame sync, active low
  input  wire logic                         serial_data_in,     // Serial data from host
  output logic                              serial_data_out,    // Readback data to host
  input  wire logic                         load_outputs_n,     // Load outputs, active low
  input  wire logic                         clear_in,           // Clear, active high
  input  wire logic                         addr_select_0,      // Address pin 0
  input  wire logic                         addr_select_1,      // Address pin 1
  output logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] dac_code, // Output registers
  output logic [`DSLC_CHANNELS-1:0]         dac_update,         // Output changed, pulse
  output logic                              frame_error,        // Bad length frame, pulse
  output logic                              packet_error_check  // Last good frame was long
);

  // Pin synchronisers and edge history
  logic [`DSLC_PIN_W-1:0] meta_q;
  logic [`DSLC_PIN_W-1:0] sync_q;
  logic                   fs_prev_q;
  logic                   ld_prev_q;

  // Channel registers
  logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] in_q;
  logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] in_d;
  logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] out_q;
  logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] out_d;

  // Readback state
  logic [1:0]             rb_ch_q;
  logic [2:0]             rb_sel_q;
  logic                   rb_load_q;
  logic [`DSLC_RB_W-1:0]  rb_q;

  // Status outputs
  logic [`DSLC_CHANNELS-1:0] update_q;
  logic                   err_q;
  logic                   long_q;

  // Link side captures
  logic [`DSLC_SHIFT_W-1:0] shift_w;
  logic [`DSLC_CNT_W-1:0]   cnt_w;
  logic                     arm_w;
  logic                     arm_meta_q;
  logic                     arm_sync_q;
  logic                     edges_q;

  // Decode nets
  wire  logic [`DSLC_PIN_W-1:0] pin_vec;
  wire  logic                fs_s;
  wire  logic                ld_s;
  wire  logic                clr_s;
  wire  logic [1:0]          addr_s;
  wire  logic                frame_end;
  wire  logic                ld_fall;
  wire  logic                len_short;
  wire  logic                len_long;
  wire  logic                len_ok;
  wire  logic                addr_ok;
  wire  logic                wr_fire;
  wire  logic                wr_out;
  wire  logic                ld_out;
  wire  logic [`DSLC_CHANNELS-1:0] ch_hit;
  wire  logic [`DSLC_DATA_W-1:0]   rb_val;
  dslc_pkg::dslc_frame_t     fr_w;
  dslc_pkg::dslc_kind_t      kind_w;
  dslc_pkg::dslc_frame_t     rb_w;

  // All pins come from outside this clock; two flops before use
  assign pin_vec = {frame_sync_n, load_outputs_n, clear_in, addr_select_1, addr_select_0};

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= `DSLC_PIN_RST;
      sync_q <= `DSLC_PIN_RST;
    end else begin
      meta_q <= pin_vec;
      sync_q <= meta_q;
    end
  end

  // Third stage only for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      fs_prev_q <= 1'b1;
      ld_prev_q <= 1'b1;
    end else begin
      fs_prev_q <= fs_s;
      ld_prev_q <= ld_s;
    end
  end

  // Synchronised levels and edges
  assign fs_s      = sync_q[4];
  assign ld_s      = sync_q[3];
  assign clr_s     = sync_q[2];
  assign addr_s    = sync_q[1:0];
  assign frame_end = fs_s & ~fs_prev_q;
  assign ld_fall   = ~ld_s & ld_prev_q;                               // R07

  // Link arm flag is preset by the sync rise, so it is always high at frame end;
  // it crosses like a pin and a sticky flag remembers that the frame saw a fall
  always_ff @(posedge clk) begin
    if (reset) begin
      arm_meta_q <= 1'b1;
      arm_sync_q <= 1'b1;
      edges_q    <= 1'b0;
    end else begin
      arm_meta_q <= arm_w;
      arm_sync_q <= arm_meta_q;
      edges_q    <= (~arm_sync_q & ~fs_s) | (edges_q & ~frame_end);   // R12
    end
  end

  // Link logic on the host clock; its words settle before the sync rise
  dslc_link u_link (
    .serial_clk      (serial_clk),
    .frame_sync_n    (frame_sync_n),
    .serial_data_in  (serial_data_in),
    .rb_word         (rb_q),
    .shift_q         (shift_w),
    .cnt_q           (cnt_w),
    .in_arm_q        (arm_w),
    .serial_data_out (serial_data_out)
  );

  // Only a 24 or 32 edge frame counts; the long one ends in check bits
  assign len_short = edges_q && (cnt_w == `DSLC_LEN_SHORT);           // R10
  assign len_long  = edges_q && (cnt_w == `DSLC_LEN_LONG);            // R10
  assign len_ok    = len_short | len_long;                            // R12

  // Payload sits at the top of a long frame, MSB first either way
  assign fr_w    = len_long ? shift_w[`DSLC_SHIFT_W-1:`DSLC_SHIFT_W-`DSLC_RB_W]
                            : shift_w[`DSLC_RB_W-1:0];                // R12
  assign addr_ok = (fr_w.dev_addr == addr_s);                         // R08

  // Frames for another device are silently ignored
  assign kind_w = !frame_end ? dslc_pkg::DSLC_KIND_NONE :
                  !len_ok    ? dslc_pkg::DSLC_KIND_DROP :             // R12
                  !addr_ok   ? dslc_pkg::DSLC_KIND_NONE :             // R08
                  fr_w.read_req ? dslc_pkg::DSLC_KIND_READ : dslc_pkg::DSLC_KIND_WRITE;

  // Write qualification; clear blocks only the output side
  assign wr_fire = (kind_w == dslc_pkg::DSLC_KIND_WRITE) && (fr_w.reg_sel == `DSLC_SEL_DATA);
  assign wr_out  = wr_fire & ~ld_s & ~clr_s;                          // R05 R11
  assign ld_out  = ld_fall & ~clr_s;                                  // R07 R11
  assign ch_hit  = 4'h1 << fr_w.channel;

  // Per channel next values; a load in the same cycle sees the new input
  for (genvar i = 0; i < `DSLC_CHANNELS; i++) begin : g_ch
    assign in_d[i]  = (wr_fire && ch_hit[i]) ? fr_w.data : in_q[i];  // R06
    assign out_d[i] = ld_out ? in_d[i] :                              // R07
                      (wr_out && ch_hit[i]) ? fr_w.data : out_q[i];   // R05
  end

  // Channel registers
  always_ff @(posedge clk) begin
    if (reset) begin
      in_q  <= {`DSLC_CHANNELS{`DSLC_DAC_RST}};
      out_q <= {`DSLC_CHANNELS{`DSLC_DAC_RST}};
    end else begin
      in_q  <= in_d;
      out_q <= out_d;
    end
  end

  // Update strobes and frame status
  always_ff @(posedge clk) begin
    if (reset) begin
      update_q <= '0;
      err_q    <= 1'b0;
      long_q   <= 1'b0;
    end else begin
      update_q <= (wr_out ? ch_hit : '0) | {`DSLC_CHANNELS{ld_out}};
      err_q    <= (kind_w == dslc_pkg::DSLC_KIND_DROP);               // R12
      long_q   <= (frame_end && len_ok) ? len_long : long_q;
    end
  end

  // Readback selection is kept from the last read frame
  always_ff @(posedge clk) begin
    if (reset) begin
      rb_ch_q  <= 2'h0;
      rb_sel_q <= `DSLC_SEL_DATA;
    end else if (kind_w == dslc_pkg::DSLC_KIND_READ) begin
      rb_ch_q  <= fr_w.channel;                                       // R04
      rb_sel_q <= fr_w.reg_sel;                                       // R04
    end
  end

  // Readback word is rebuilt once per frame end only, so it never
  // moves while the host is clocking it out
  assign rb_val = (rb_sel_q == `DSLC_SEL_OUTPUT) ? out_q[rb_ch_q] : in_q[rb_ch_q];
  assign rb_w   = '{read_req: 1'b0, dev_addr: addr_s, channel: rb_ch_q,
                    reg_sel: rb_sel_q, data: rb_val};

  always_ff @(posedge clk) begin
    if (reset) begin
      rb_load_q <= 1'b0;
      rb_q      <= `DSLC_RB_RST;
    end else begin
      rb_load_q <= frame_end;
      rb_q      <= rb_load_q ? rb_w : rb_q;                           // R04
    end
  end

  // Outputs straight from flops
  assign dac_code           = out_q;
  assign dac_update         = update_q;
  assign frame_error        = err_q;
  assign packet_error_check = long_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_wr_direct;
    wr_out |=> (out_q[$past(fr_w.channel)] == $past(fr_w.data)) &&
               (dac_update == ($past(ch_hit) | {`DSLC_CHANNELS{$past(ld_out)}})) ##1
               (dac_code == $past(out_q));
  endproperty
  a_wr_direct: assert property (p_wr_direct) else $error("direct write missed output"); // R05

  property p_wr_staged;
    (wr_fire && ld_s && !ld_fall) |=> (out_q == $past(out_q)) &&
                                     (in_q[$past(fr_w.channel)] == $past(fr_w.data));
  endproperty
  a_wr_staged: assert property (p_wr_staged) else $error("staged write moved output"); // R06

  property p_ld_all;
    (ld_fall && !clr_s && !wr_fire) |=> (out_q == $past(in_q)) && (&dac_update);
  endproperty
  a_ld_all: assert property (p_ld_all) else $error("load did not copy all channels"); // R07

  property p_addr;
    (frame_end && len_ok && !addr_ok) |=> $stable(in_q) && $stable(out_q) && $stable(rb_sel_q);
  endproperty
  a_addr: assert property (p_addr) else $error("foreign frame acted"); // R08

  property p_clear;
    clr_s |=> $stable(out_q) && (dac_update == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("output written under clear"); // R11

  property p_len;
    (frame_end && !len_ok) |=> $stable(in_q) && $stable(out_q) && frame_error;
  endproperty
  a_len: assert property (p_len) else $error("bad length frame acted"); // R12

endmodule

// ### tb/dslc_host_model.sv
// Purpose: Host side of the serial link, drives frames and reads back
// Assumes: Serial clock idles low and stops between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps

module dslc_host_model #(
  parameter int HALF_NS = 18  // Half period; 36 ns keeps the link under 30 MHz
) (
  output logic      serial_clk,      // Link clock, only within frames
  output logic      frame_sync_n,    // Frame sync, active low
  output logic      serial_data_in,  // Write bits toward the device
  input  wire logic serial_data_out  // Readback bits from the device
);
  // Idle state: clock low, frame sync high; an early rise presets the link's frame state
  initial begin
    serial_clk     = 1'b0;
    frame_sync_n   = 1'b0;
    serial_data_in = 1'b0;
    #5;
    frame_sync_n   = 1'b1;
  end

  // One frame; data changes on the rise so it is steady at each fall
  task automatic send_frame(input logic [31:0] bits, input int nbits, output logic [23:0] rd);
    rd           = 24'h00_0000;
    frame_sync_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      #(HALF_NS);
      serial_data_in = bits[31-i];
      serial_clk     = 1'b1;
      #(HALF_NS);
      if (i < 24) begin
        rd[23-i] = serial_data_out;
      end
      serial_clk = 1'b0;
    end
    #(HALF_NS);
    frame_sync_n   = 1'b1;
    serial_data_in = ~serial_data_in;    // Released line, no stale value
    #400;                                // Gap well above 8 system clocks
  endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the DAC serial load front end
// Assumes: Host model drives the link, bench drives the side pins
// Notes:   Pulses are gathered on the falling system clock edge
`timescale 1ns/1ps
`include "dslc_regs.svh"

module tb;
  logic                                        clk, reset, load_outputs_n, clear_in;
  logic                                        addr_select_0, addr_select_1;
  logic                                        serial_clk, frame_sync_n, serial_data_in, serial_data_out;
  logic [`DSLC_CHANNELS-1:0][`DSLC_DATA_W-1:0] dac_code;
  logic [`DSLC_CHANNELS-1:0]                   dac_update, upd_seen;
  logic                                        frame_error, packet_error_check, err_seen;
  logic [23:0]                                 rd;
  logic [15:0]                                 exp_code [4];
  int                                          fail_count, checks_done, upd_cycles;

  dslc_top u_dut (.clk(clk), .reset(reset), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .load_outputs_n(load_outputs_n),
    .clear_in(clear_in), .addr_select_0(addr_select_0), .addr_select_1(addr_select_1),
    .dac_code(dac_code), .dac_update(dac_update), .frame_error(frame_error),
    .packet_error_check(packet_error_check));

  dslc_host_model u_host (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // One-cycle pulses are caught here so tasks need not race them
  always @(negedge clk) begin
    if (dac_update !== 4'h0) begin
      upd_seen   = upd_seen | dac_update;
      upd_cycles = upd_cycles + 1;
    end
    if (frame_error === 1'b1) begin
      err_seen = 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Side pins change just after a rising edge, then settle through the syncs
  task automatic set_pins(input logic ld_n, input logic clr, input logic [1:0] ad);
    @(posedge clk);
    #2;
    load_outputs_n = ld_n;
    clear_in       = clr;
    {addr_select_1, addr_select_0} = ad;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [31:0] mk(logic r, logic [1:0] dev, logic [1:0] ch, logic [2:0] sel, logic [15:0] d);
    dslc_pkg::dslc_frame_t f;
    f = '{read_req: r, dev_addr: dev, channel: ch, reg_sel: sel, data: d};
    return {f, 8'h00};
  endfunction

  task automatic xfer(input logic [31:0] b, input int n);
    upd_seen   = 4'h0;
    err_seen   = 1'b0;
    upd_cycles = 0;
    u_host.send_frame(b, n, rd);
  endtask

  task automatic codes_match(input string what);
    for (int c = 0; c < 4; c++) begin
      check(what, {16'h0000, exp_code[c]}, {16'h0000, dac_code[c]});
    end
  endtask

  // Load held low: each write reaches its output at frame end
  task automatic t_direct();
    logic [15:0] vals [4];
    vals = '{16'h8001, 16'hFFFF, 16'h0000, 16'h7FFE};
    for (int c = 0; c < 4; c++) begin
      xfer(mk(1'b0, 2'b10, c[1:0], 3'h0, vals[c]), 24);
      exp_code[c] = vals[c];
      check("update", 32'(4'h1 << c), 32'(upd_seen));
    end
    codes_match("direct code");
    $display("test direct done");
  endtask

  // Foreign address ignored; pins moved to match are accepted
  task automatic t_address();
    xfer(mk(1'b0, 2'b01, 2'd3, 3'h0, 16'h1357), 24);
    check("foreign update", 32'h0, 32'(upd_seen));
    set_pins(1'b0, 1'b0, 2'b01);
    xfer(mk(1'b0, 2'b01, 2'd3, 3'h0, 16'h1357), 24);
    exp_code[3] = 16'h1357;
    codes_match("address code");
    set_pins(1'b0, 1'b0, 2'b10);
    $display("test address done");
  endtask

  // Wrong lengths refused; long frame carries its check byte
  task automatic t_length();
    int lens [3];
    lens = '{23, 25, 31};
    for (int k = 0; k < 3; k++) begin
      xfer(mk(1'b0, 2'b10, 2'd0, 3'h0, 16'hDEAD), lens[k]);
      check("length error", 32'h1, 32'(err_seen));
      check("length update", 32'h0, 32'(upd_seen));
    end
    codes_match("length code");
    xfer(mk(1'b0, 2'b10, 2'd1, 3'h0, 16'h4242) | 32'h0000_005A, 32);
    exp_code[1] = 16'h4242;
    check("long flag", 32'h1, 32'(packet_error_check));
    xfer(mk(1'b0, 2'b10, 2'd1, 3'h0, 16'h4243), 24);
    exp_code[1] = 16'h4243;
    check("short flag", 32'h0, 32'(packet_error_check));
    codes_match("long code");
    $display("test length done");
  endtask

  // Clear blocks output writes even with load low
  task automatic t_clear();
    set_pins(1'b0, 1'b1, 2'b10);
    xfer(mk(1'b0, 2'b10, 2'd1, 3'h0, 16'h0F0F), 24);
    check("clear update", 32'h0, 32'(upd_seen));
    codes_match("clear code");
    set_pins(1'b0, 1'b0, 2'b10);
    $display("test clear done");
  endtask

  // Load high stages inputs; the falling load moves all four together
  task automatic t_staged();
    set_pins(1'b1, 1'b0, 2'b10);
    for (int c = 0; c < 4; c++) begin
      xfer(mk(1'b0, 2'b10, c[1:0], 3'h0, 16'hA500 + 16'(c)), 24);
      check("staged update", 32'h0, 32'(upd_seen));
    end
    codes_match("staged code");
    upd_seen   = 4'h0;
    upd_cycles = 0;
    set_pins(1'b0, 1'b0, 2'b10);
    for (int c = 0; c < 4; c++) begin
      exp_code[c] = 16'hA500 + 16'(c);
    end
    codes_match("loaded code");
    check("load update", 32'hF, 32'(upd_seen));
    check("load cycles", 32'h1, 32'(upd_cycles));
    $display("test staged done");
  endtask

  // Read request, then the word leaves in the next frame; staged input differs from output
  task automatic t_readback();
    logic [15:0] want;
    set_pins(1'b1, 1'b0, 2'b10);
    xfer(mk(1'b0, 2'b10, 2'd2, 3'h0, 16'h5AC3), 24);
    for (int s = 0; s < 2; s++) begin
      want = (s == 0) ? 16'h5AC3 : exp_code[2];
      xfer(mk(1'b1, 2'b10, 2'd2, 3'(s), 16'h0000), 24);
      xfer(mk(1'b0, 2'b01, 2'd0, 3'h0, 16'hFFFF), 24);
      check("readback", {8'h00, 1'b0, 2'b10, 2'd2, 3'(s), want}, {8'h00, rd});
    end
    set_pins(1'b0, 1'b0, 2'b10);
    exp_code[2] = 16'h5AC3;
    codes_match("readback code");
    $display("test readback done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under 100 us
  initial begin
    #300000;
    fail_count++;
    $display("watchdog expired");
    close_out();
  end

  // Main sequence
  initial begin
    clk            = 1'b0;
    reset          = 1'b1;
    load_outputs_n = 1'b0;
    clear_in       = 1'b0;
    addr_select_0  = 1'b0;
    addr_select_1  = 1'b1;
    fail_count     = 0;
    checks_done    = 0;
    upd_cycles     = 0;
    upd_seen       = 4'h0;
    err_seen       = 1'b0;
    for (int c = 0; c < 4; c++) begin
      exp_code[c] = 16'h0000;
    end
    repeat (20) @(posedge clk);
    #2;
    reset = 1'b0;
    repeat (8) @(posedge clk);
    t_direct();
    t_address();
    t_length();
    t_clear();
    t_staged();
    t_readback();
    close_out();
  end
endmodule
